// >>> rtl/dcc_params.svh
// Register map, field positions and reset values of the DMA channel control block
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define DCC_CTRL_OFS      12'h000
`define DCC_STAT_OFS      12'h004
`define DCC_MASK_OFS      12'h008
`define DCC_ADDR_W        12

// ==========================================================================
// Control register fields
// ==========================================================================
`define DCC_BUSY_BIT      15
`define DCC_CHNS_BIT      8
`define DCC_EN_BIT        7
`define DCC_AED_BIT       6
`define DCC_CHN_BIT       5
`define DCC_AEN_BIT       4
`define DCC_EDET_BIT      2
`define DCC_PRI_LSB       0
`define DCC_CTRL_WMASK    32'h0000_01F3
`define DCC_CTRL_RST      32'h0000_0000

// ==========================================================================
// Interrupt status bits
// ==========================================================================
`define DCC_IRQ_W         3
`define DCC_IRQ_DONE      0
`define DCC_IRQ_ABORT     1
`define DCC_IRQ_CHAIN     2
`define DCC_MASK_RST      3'h0

// ==========================================================================
// Suspend drain time after enable is cleared
// ==========================================================================
`define DCC_DRAIN_CYC     4'h3

`endif

// >>> rtl/dcc_pkg.sv
// Types shared by the DMA channel control block
package dcc_pkg;
   // Channel sequencing states
   typedef enum logic [1:0] {
      IDLE,
      ACTIVE,
      DRAIN
   } dcc_state_type;

   // AXI response codes
   typedef logic [1:0] dcc_resp_type;
endpackage

// >>> rtl/dcc_axil_slave.sv
// AXI4-Lite slave front end that turns bus accesses into one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"

module dcc_axil_slave
   import dcc_pkg::*;
(
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst,
   // Write channels
   input  wire logic [`DCC_ADDR_W-1:0] awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   // Read channels
   input  wire logic [`DCC_ADDR_W-1:0] araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   // Register side
   output logic                        wrStb,
   output logic [`DCC_ADDR_W-1:0]      wrAddr,
   output logic [31:0]                 wrData,
   output logic [3:0]                  wrStrb,
   input  wire logic                   wrOk,
   output logic                        rdStb,
   output logic [`DCC_ADDR_W-1:0]      rdAddr,
   input  wire logic [31:0]            rdData,
   input  wire logic                   rdOk
);
   // ==========================================================================
   // Write path: hold address and data until both are present
   // ==========================================================================
   logic                   awHeld_ff;  // Address captured
   logic                   wHeld_ff;   // Data captured
   logic [`DCC_ADDR_W-1:0] awAddr_ff;  // Captured address
   logic [31:0]            wData_ff;   // Captured data
   logic [3:0]             wStrb_ff;   // Captured strobes
   logic                   bValid_ff;  // Write answer pending
   logic [1:0]             bResp_ff;   // Write answer code

   // Accept each channel only while no answer waits
   assign awready = !awHeld_ff && !bValid_ff;
   assign wready  = !wHeld_ff && !bValid_ff;
   assign wrStb   = awHeld_ff && wHeld_ff && !bValid_ff;
   assign wrAddr  = awAddr_ff;
   assign wrData  = wData_ff;
   assign wrStrb  = wStrb_ff;
   assign bvalid  = bValid_ff;
   assign bresp   = bResp_ff;

   // Capture and answer
   always_ff @(posedge mclk) begin
      if (rst) begin
         awHeld_ff <= 1'b0;
         wHeld_ff  <= 1'b0;
         awAddr_ff <= '0;
         wData_ff  <= 32'h0000_0000;
         wStrb_ff  <= 4'h0;
         bValid_ff <= 1'b0;
         bResp_ff  <= 2'h0;
      end else begin
         if (awvalid && awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld_ff <= 1'b1;
            wData_ff <= wdata;
            wStrb_ff <= wstrb;
         end
         // Strobe consumes both halves, answer next cycle
         if (wrStb) begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            bValid_ff <= 1'b1;
            bResp_ff  <= wrOk ? 2'h0 : 2'h2;
         end else if (bValid_ff && bready) begin
            bValid_ff <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Read path: single-cycle lookup, data registered
   // ==========================================================================
   logic        rValid_ff;  // Read answer pending
   logic [31:0] rData_ff;   // Read data held for the master
   logic [1:0]  rResp_ff;   // Read answer code

   assign arready = !rValid_ff;
   assign rdStb   = arvalid && arready;
   assign rdAddr  = araddr;
   assign rvalid  = rValid_ff;
   assign rdata   = rData_ff;
   assign rresp   = rResp_ff;

   // Answer every read one cycle after it is taken
   always_ff @(posedge mclk) begin
      if (rst) begin
         rValid_ff <= 1'b0;
         rData_ff  <= 32'h0000_0000;
         rResp_ff  <= 2'h0;
      end else if (rdStb) begin
         rValid_ff <= 1'b1;
         rData_ff  <= rdOk ? rdData : 32'h0000_0000;
         rResp_ff  <= rdOk ? 2'h0 : 2'h2;
      end else if (rValid_ff && rready) begin
         rValid_ff <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/dcc_channel_ctrl.sv
// DMA channel control register, enable sequencing and chaining logic
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"

module dcc_channel_ctrl
   import dcc_pkg::*;
(
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst,
   // AXI4-Lite write channels
   input  wire logic [`DCC_ADDR_W-1:0] awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   // AXI4-Lite read channels
   input  wire logic [`DCC_ADDR_W-1:0] araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   // Channel events, one-cycle pulses from the same clock domain, and the xferIdle level
   input  wire logic                   startEvt,
   input  wire logic                   abortEvt,
   input  wire logic                   blockDone,
   input  wire logic                   xferIdle,
   // Completion pulses of the neighbouring channels
   input  wire logic                   lowerDone,
   input  wire logic                   higherDone,
   // Channel outputs
   output logic                        chanRun,
   output logic                        chanAbort,
   output logic [1:0]                  chanPriority,
   output logic                        channelBusyFlag,
   output logic                        irq
);
   // ==========================================================================
   // Bus front end
   // ==========================================================================
   logic                   wrStb;   // Write strobe
   logic [`DCC_ADDR_W-1:0] wrAddr;  // Write address
   logic [31:0]            wrData;  // Write data
   logic [3:0]             wrStrb;  // Write byte enables
   logic                   rdStb;   // Read strobe
   logic [`DCC_ADDR_W-1:0] rdAddr;  // Read address
   logic [31:0]            rdData;  // Read mux result
   logic                   wrOk;    // Write hits a register
   logic                   rdOk;    // Read hits a register

   dcc_axil_slave u_bus (
      .mclk    (mclk),
      .rst     (rst),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wrStb   (wrStb),
      .wrAddr  (wrAddr),
      .wrData  (wrData),
      .wrStrb  (wrStrb),
      .wrOk    (wrOk),
      .rdStb   (rdStb),
      .rdAddr  (rdAddr),
      .rdData  (rdData),
      .rdOk    (rdOk)
   );

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] mergeLanes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction

   // ==========================================================================
   // Address decode
   // ==========================================================================
   wire wrCtrl = wrStb && (wrAddr == `DCC_CTRL_OFS);
   wire wrMask = wrStb && (wrAddr == `DCC_MASK_OFS);
   wire rdStat = rdStb && (rdAddr == `DCC_STAT_OFS);
   assign wrOk = (wrAddr == `DCC_CTRL_OFS) || (wrAddr == `DCC_MASK_OFS)
              || (wrAddr == `DCC_STAT_OFS);
   assign rdOk = (rdAddr == `DCC_CTRL_OFS) || (rdAddr == `DCC_MASK_OFS)
              || (rdAddr == `DCC_STAT_OFS);

   // ==========================================================================
   // Control register fields
   // ==========================================================================
   logic       chainDir_ff;  // 1 = follow lower neighbour
   logic       enable_ff;    // Channel enable
   logic       allowEvt_ff;  // Keep events while disabled
   logic       chainAllow_ff;// Chaining permitted
   logic       autoEn_ff;    // Stay enabled after block
   logic       evtDet_ff;    // Event seen, read-only
   logic [1:0] prio_ff;      // Channel priority

   wire [31:0] wrMerged = mergeLanes(`DCC_CTRL_RST, wrData, wrStrb);
   wire        curEnable = enable_ff;

   // Chain trigger: direction only counts when chaining is allowed
   wire chainSrc  = chainDir_ff ? lowerDone : higherDone;
   wire chainKick = chainAllow_ff && chainSrc;

   // Events are taken when enabled, or when disabled-event capture is on
   wire evtGate   = enable_ff || allowEvt_ff;
   wire startTake = startEvt && evtGate;
   wire abortTake = abortEvt && evtGate;

   // Which byte lanes software writes this cycle
   wire wrLane0 = wrCtrl && wrStrb[0];
   wire wrLane1 = wrCtrl && wrStrb[1];

   // Next enable: software, then block end, then chaining; abort wins last
   logic nxt_enable;
   always_comb begin
      nxt_enable = enable_ff;
      if (wrLane0) begin
         nxt_enable = wrMerged[`DCC_EN_BIT];
      end
      if (blockDone && !autoEn_ff) begin
         nxt_enable = 1'b0;
      end
      if (chainKick) begin
         nxt_enable = 1'b1;
      end
      if (abortTake) begin
         nxt_enable = 1'b0;
      end
   end

   // Field update; event flag follows hardware only
   always_ff @(posedge mclk) begin
      if (rst) begin
         chainDir_ff   <= 1'b0;
         enable_ff     <= 1'b0;
         allowEvt_ff   <= 1'b0;
         chainAllow_ff <= 1'b0;
         autoEn_ff     <= 1'b0;
         evtDet_ff     <= 1'b0;
         prio_ff       <= 2'h0;
      end else begin
         enable_ff <= nxt_enable;
         if (wrLane0) begin
            allowEvt_ff   <= wrMerged[`DCC_AED_BIT];
            chainAllow_ff <= wrMerged[`DCC_CHN_BIT];
            autoEn_ff     <= wrMerged[`DCC_AEN_BIT];
            prio_ff       <= wrMerged[`DCC_PRI_LSB +: 2];
         end
         if (wrLane1) begin
            chainDir_ff <= wrMerged[`DCC_CHNS_BIT];
         end
         if (startTake || abortTake) begin
            evtDet_ff <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Run/drain sequencing
   // ==========================================================================
   dcc_state_type state_ff;  // Channel activity state
   logic [3:0]    drain_ff;  // Least drain count before idle

   // Channel becomes active on a taken start while enabled
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_ff <= IDLE;
         drain_ff <= 4'h0;
      end else begin
         unique case (state_ff)
            IDLE: begin
               if (startTake && enable_ff) begin
                  state_ff <= ACTIVE;
               end
            end
            ACTIVE: begin
               // Losing enable lets the current transaction finish
               if (!enable_ff || blockDone) begin
                  state_ff <= DRAIN;
                  drain_ff <= `DCC_DRAIN_CYC;
               end
            end
            DRAIN: begin
               if (drain_ff != 4'h0) begin
                  drain_ff <= drain_ff - 4'h1;
               end else if (xferIdle) begin
                  state_ff <= IDLE;
               end
            end
         endcase
      end
   end

   wire active = (state_ff != IDLE);
   assign channelBusyFlag = active || curEnable;
   assign chanRun         = (state_ff == ACTIVE) && enable_ff;
   assign chanAbort       = abortTake;
   assign chanPriority    = prio_ff;

   // ==========================================================================
   // Interrupt status and mask
   // ==========================================================================
   logic [`DCC_IRQ_W-1:0] irqStat_ff;  // Sticky event bits
   logic [`DCC_IRQ_W-1:0] irqMask_ff;  // Enables onto irq

   wire [`DCC_IRQ_W-1:0] irqSet = {chainKick, abortTake, blockDone};

   // Read of status clears it; a simultaneous new event survives
   always_ff @(posedge mclk) begin
      if (rst) begin
         irqStat_ff <= '0;
         irqMask_ff <= `DCC_MASK_RST;
      end else begin
         irqStat_ff <= (rdStat ? '0 : irqStat_ff) | irqSet;
         if (wrMask && wrStrb[0]) begin
            irqMask_ff <= wrData[`DCC_IRQ_W-1:0];
         end
      end
   end
   assign irq = |(irqStat_ff & irqMask_ff);

   // ==========================================================================
   // Read mux; unimplemented bits read zero
   // ==========================================================================
   wire [31:0] ctrlWord = {16'h0000, channelBusyFlag, 6'h00, chainDir_ff,
                           enable_ff, allowEvt_ff, chainAllow_ff, autoEn_ff,
                           1'b0, evtDet_ff, prio_ff};
   assign rdData = (rdAddr == `DCC_CTRL_OFS) ? ctrlWord :
                   (rdAddr == `DCC_STAT_OFS) ? {29'h0, irqStat_ff} :
                   (rdAddr == `DCC_MASK_OFS) ? {29'h0, irqMask_ff} : 32'h0000_0000;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   a_busy_when_en: assert property (@(posedge mclk) disable iff (rst)
      enable_ff |-> channelBusyFlag)
      else $error("busy low while enabled");

   a_chain_lower: assert property (@(posedge mclk) disable iff (rst)
      (chainAllow_ff && chainDir_ff && lowerDone && !abortTake) |=> enable_ff)
      else $error("lower chain did not enable");

   a_chain_higher: assert property (@(posedge mclk) disable iff (rst)
      (chainAllow_ff && !chainDir_ff && higherDone && !abortTake) |=> enable_ff)
      else $error("higher chain did not enable");

   a_no_chain: assert property (@(posedge mclk) disable iff (rst)
      (!chainAllow_ff && !enable_ff && !wrLane0) |=> !enable_ff)
      else $error("channel enabled without chaining allowed");

   a_evt_ignored: assert property (@(posedge mclk) disable iff (rst)
      (!enable_ff && !allowEvt_ff && !evtDet_ff) |=> !evtDet_ff)
      else $error("event kept while disabled");

   a_auto_off: assert property (@(posedge mclk) disable iff (rst)
      (blockDone && !autoEn_ff && !chainKick) |=> !enable_ff)
      else $error("enable kept after block");

   a_evt_sticky: assert property (@(posedge mclk) disable iff (rst)
      evtDet_ff |=> evtDet_ff)
      else $error("event flag cleared by software");

   a_zero_bits: assert property (@(posedge mclk) disable iff (rst)
      (ctrlWord[31:16] == 16'h0000) && (ctrlWord[14:9] == 6'h00) && !ctrlWord[3])
      else $error("unimplemented bit reads one");

   a_drain_hold: assert property (@(posedge mclk) disable iff (rst)
      (state_ff == ACTIVE && !enable_ff) |=> channelBusyFlag [*3])
      else $error("busy dropped before drain");

   a_prio_load: assert property (@(posedge mclk) disable iff (rst)
      wrLane0 |=> (prio_ff == $past(wrMerged[1:0])))
      else $error("priority not stored");
endmodule
`default_nettype wire

// >>> testbench/dcc_far_side.sv
// Model of the data mover, neighbour channels and event sources
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Far side of the channel
// ==========================================================================
module dcc_far_side (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Bench requests and channel state
   input  wire logic [4:0] evtReq,
   input  wire logic [3:0] idleHold,
   input  wire logic       chanRun,
   // Pulses and status toward the channel
   output logic            startEvt,
   output logic            abortEvt,
   output logic            blockDone,
   output logic            lowerDone,
   output logic            higherDone,
   output logic            xferIdle
);
   logic [4:0] pulse_ff;   // One-cycle event pulses
   logic [3:0] hold_ff;    // Cycles left on the last transaction

   // Pulses last one cycle; a transaction outlives the run by idleHold cycles
   always_ff @(posedge mclk) begin
      if (rst) begin
         pulse_ff <= 5'h00;
         hold_ff  <= 4'h0;
      end else begin
         pulse_ff <= evtReq;
         hold_ff  <= chanRun ? idleHold : (hold_ff != 4'h0 ? hold_ff - 4'h1 : 4'h0);
      end
   end

   assign startEvt   = pulse_ff[0];
   assign abortEvt   = pulse_ff[1];
   assign blockDone  = pulse_ff[2];
   assign lowerDone  = pulse_ff[3];
   assign higherDone = pulse_ff[4];
   // A slow tail makes the channel wait before suspending
   assign xferIdle   = !chanRun && hold_ff == 4'h0;
endmodule
`default_nettype wire

// >>> testbench/dcc_channel_ctrl_tb_top.sv
// Self-checking bench of the DMA channel control block
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"

// ==========================================================================
// Bench top
// ==========================================================================
module dcc_channel_ctrl_tb_top import dcc_pkg::*; ;
   localparam logic [11:0] CTL = `DCC_CTRL_OFS;
   localparam logic [11:0] STA = `DCC_STAT_OFS;
   localparam logic [11:0] MSK = `DCC_MASK_OFS;
   logic        mclk = 1'b0;                   // 50 MHz clock
   logic        rst = 1'b1;                    // Held for 16 cycles
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [3:0]  wstrb = 4'hF;                  // Full words only
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, chanRun, chanAbort, busy, irq;
   logic [1:0]  bresp, rresp, chanPriority;
   logic        startEvt, abortEvt, blockDone, xferIdle, lowerDone, higherDone;
   logic [4:0]  evtReq = 5'h00;                // Pulse requests to the far side
   logic [3:0]  idleHold = 4'h1;               // Tail of the last transaction
   int          failCount = 0, samplesChecked = 0;

   // Clock generator
   always #10 mclk = ~mclk;

   dcc_channel_ctrl dcc_channel_ctrl_i (.mclk(mclk), .rst(rst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .startEvt(startEvt), .abortEvt(abortEvt), .blockDone(blockDone),
      .xferIdle(xferIdle), .lowerDone(lowerDone), .higherDone(higherDone),
      .chanRun(chanRun), .chanAbort(chanAbort), .chanPriority(chanPriority),
      .channelBusyFlag(busy), .irq(irq));
   dcc_far_side dcc_far_side_i (.mclk(mclk), .rst(rst), .evtReq(evtReq),
      .idleHold(idleHold), .chanRun(chanRun), .startEvt(startEvt), .abortEvt(abortEvt),
      .blockDone(blockDone), .lowerDone(lowerDone), .higherDone(higherDone),
      .xferIdle(xferIdle));

   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         failCount++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("Checks %0d, mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // A wait that ran out ends the run
   task automatic tmo(input string what);
      failCount++;
      $display("wrong value %s expected answer seen timeout", what);
      summarize();
   endtask

   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic got;
      got = 1'b0;
      @(posedge mclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 40 && !got; n++) begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            check("write response", 32'(bresp), 32'(er));
            bready <= 1'b0;
            got = 1'b1;
         end
      end
      if (!got) tmo("write response");
      #1;
   endtask

   // Read and compare the bits under m
   task automatic rdChk(input logic [11:0] a, input logic [31:0] e, m, input logic [1:0] er);
      logic got;
      got = 1'b0;
      @(posedge mclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 40 && !got; n++) begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            check("read data", rdata & m, e);
            check("read response", 32'(rresp), 32'(er));
            rready <= 1'b0;
            got = 1'b1;
         end
      end
      if (!got) tmo("read answer");
      #1;
   endtask

   // One event pulse; ab is the abort output in the pulse cycle
   task automatic pulse(input int i, output logic ab);
      @(posedge mclk);
      evtReq[i] <= 1'b1;
      @(posedge mclk);
      evtReq[i] <= 1'b0;
      #1 ab = chanAbort;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   // Wait on the busy output port, not the register bit, counting cycles
   task automatic waitIdle(output int n);
      for (n = 0; n < 40 && busy !== 1'b0; n++) @(posedge mclk);
      if (busy !== 1'b0) tmo("busy release");
      #1;
   endtask

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic t_fields;
      int n;
      rdChk(CTL, 32'h0000_0000, 32'hFFFF_FFFF, 2'h0);
      rdChk(MSK, 32'h0000_0000, 32'hFFFF_FFFF, 2'h0);
      check("irq", 32'(irq), 32'h0);
      wr(CTL, 32'hFFFF_FFFF, 2'h0);
      check("busy", 32'(busy), 32'h1);
      rdChk(CTL, 32'h0000_81F3, 32'hFFFF_FFFF, 2'h0);
      for (int p = 0; p < 4; p++) begin
         wr(CTL, 32'(p), 2'h0);
         waitIdle(n);
         check("priority", 32'(chanPriority), 32'(p));
         rdChk(CTL, 32'(p), 32'hFFFF_FFFF, 2'h0);
      end
      $display("field test done");
   endtask

   task automatic t_events;
      logic ab;
      wr(CTL, 32'h0000_0000, 2'h0);
      pulse(0, ab);
      check("run", 32'(chanRun), 32'h0);
      pulse(1, ab);
      check("abort", 32'(ab), 32'h0);
      rdChk(CTL, 32'h0000_0000, 32'h0000_7FFF, 2'h0);
      wr(CTL, 32'h0000_0040, 2'h0);
      pulse(1, ab);
      check("abort", 32'(ab), 32'h1);
      rdChk(CTL, 32'h0000_0044, 32'h0000_7FFF, 2'h0);
      rdChk(STA, 32'h0000_0002, 32'h0000_0002, 2'h0);
      $display("event test done");
   endtask

   task automatic t_block;
      logic ab;
      int n;
      wr(MSK, 32'h0000_0001, 2'h0);
      wr(CTL, 32'h0000_0080, 2'h0);
      pulse(0, ab);
      check("run", 32'(chanRun), 32'h1);
      pulse(2, ab);
      rdChk(CTL, 32'h0000_0004, 32'h0000_00FF, 2'h0);
      check("irq", 32'(irq), 32'h1);
      rdChk(STA, 32'h0000_0001, 32'h0000_0007, 2'h0);
      check("irq", 32'(irq), 32'h0);
      waitIdle(n);
      wr(CTL, 32'h0000_0090, 2'h0);
      pulse(0, ab);
      pulse(2, ab);
      rdChk(CTL, 32'h0000_0094, 32'h0000_00FF, 2'h0);
      pulse(0, ab);
      check("run", 32'(chanRun), 32'h1);
      idleHold <= 4'h8;
      wr(CTL, 32'h0000_0010, 2'h0);
      check("run", 32'(chanRun), 32'h0);
      check("busy", 32'(busy), 32'h1);
      waitIdle(n);
      check("drain", 32'(n >= 4), 32'h1);
      rdChk(STA, 32'h0000_0001, 32'h0000_0007, 2'h0);
      $display("block test done");
   endtask

   task automatic t_chain;
      logic ab;
      int n;
      wr(CTL, 32'h0000_0100, 2'h0);
      pulse(3, ab);
      pulse(4, ab);
      rdChk(CTL, 32'h0000_0104, 32'h0000_01FF, 2'h0);
      wr(CTL, 32'h0000_0120, 2'h0);
      pulse(4, ab);
      rdChk(CTL, 32'h0000_0124, 32'h0000_01FF, 2'h0);
      pulse(3, ab);
      rdChk(CTL, 32'h0000_01A4, 32'h0000_01FF, 2'h0);
      wr(CTL, 32'h0000_0020, 2'h0);
      waitIdle(n);
      pulse(3, ab);
      rdChk(CTL, 32'h0000_0024, 32'h0000_01FF, 2'h0);
      pulse(4, ab);
      rdChk(CTL, 32'h0000_00A4, 32'h0000_01FF, 2'h0);
      rdChk(STA, 32'h0000_0004, 32'h0000_0004, 2'h0);
      wr(CTL, 32'h0000_0000, 2'h0);
      waitIdle(n);
      $display("chain test done");
   endtask

   // Unmapped place answers with an error and changes nothing
   task automatic t_bus;
      wr(12'h00C, 32'hFFFF_FFFF, 2'h2);
      rdChk(12'h00C, 32'h0000_0000, 32'hFFFF_FFFF, 2'h2);
      rdChk(CTL, 32'h0000_0004, 32'hFFFF_FFFF, 2'h0);
      $display("bus test done");
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      t_fields();
      t_events();
      t_block();
      t_chain();
      t_bus();
      summarize();
   end
endmodule
`default_nettype wire
